// ---- hdl/paged_addr_pkg.sv ----
// shared constants and carriers for the paged effective address unit
package paged_addr_pkg;
    localparam int ADDR_W      = 14;
    localparam int PAGE_W      = 6;
    localparam int BYTE_W      = 8;
    localparam int WORD_W      = 16;
    localparam int PAGE_BYTES  = 256;
    localparam int BLOCK_PAGES = 8;
    localparam int IRQ_LINES   = 8;
    localparam int IRQ_STD     = 4;
    localparam int IRQ_BLK_SH  = 3;
    localparam int ROM_BYTES   = 64;
    localparam int AUTO_INC_BIT  = 0;
    localparam int AUTO_SKIP_BIT = 1;
    localparam logic [13:0] RESTART_ADDR = 14'h0000;
    localparam logic [13:0] IRQ_BASE     = 14'h0100;
    localparam logic [5:0]  PAGE_ZERO    = 6'h00;
    localparam logic [5:0]  TOP_PAGE_MAX = 6'h3f;
    localparam logic [2:0]  MEM_BLOCKS_RST = 3'h7;

    typedef struct packed {
        logic        indirect;
        logic        page_zero;
        logic [7:0]  offset;
        logic [13:0] instr_last;
    } mem_ref_t;

    typedef struct packed {
        logic [13:0] addr;
        logic        auto_increment_flag;
        logic        auto_skip_flag;
        logic        fault;
    } ea_result_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HI   = 4'b0010,
        ST_LO   = 4'b0100,
        ST_DONE = 4'b1000
    } ea_state_t;
endpackage

// ---- hdl/paged_effective_address_unit.sv ----
// effective address formation, dedicated locations and read-only boot area
`timescale 1ns/1ps
module paged_effective_address_unit
    import paged_addr_pkg::*;
(
    input  wire logic        ref_clk,        // processor clock
    input  wire logic        rst,            // async power-up reset
    input  wire logic        clk_en,         // freezes all state when low
    input  wire logic        req_valid,      // memory reference request
    input  wire mem_ref_t    req,            // request fields
    output logic             req_ready,      // unit idle, request taken
    output logic             res_valid,      // one-cycle result pulse
    output ea_result_t       res,            // effective address result
    output logic             rd_req,         // core read strobe
    output logic [13:0]      rd_addr,        // core read address
    input  wire logic        rd_ack,         // core read data valid
    input  wire logic [7:0]  rd_data,        // core read byte
    input  wire logic        wr_req_in,      // write request from cpu
    input  wire logic [13:0] wr_addr_in,     // write address from cpu
    output logic             wr_allow,       // write may reach core
    input  wire logic        panel_fitted,   // auto-load panel pin
    input  wire logic [2:0]  mem_blocks,     // installed 2K blocks minus one
    input  wire logic [7:0]  irq_enable,     // per-line service enable
    input  wire logic [3:0]  irq_opt_fit,    // optional lines 4-7 fitted
    input  wire logic [2:0]  irq_line,       // line to vector
    output logic [13:0]      irq_vector,     // service block start
    output logic             irq_line_ok,    // line exists and is enabled
    output logic [13:0]      restart_addr,   // restart point after reset
    output logic [7:0]       irq_blk_hit,    // write hit live service block
    output logic [5:0]       top_page        // highest valid page
);

    ////////////////////////////////////////////////////////////////////////
    // address helpers

    function automatic logic [13:0] make_addr(input logic [5:0] pg,
                                              input logic [7:0] idx);
        make_addr = {pg, idx};
    endfunction

    function automatic logic [5:0] page_of(input logic [13:0] a);
        page_of = a[13:8];
    endfunction

    // pages past installed memory report a fault instead of wrapping
    function automatic logic above_top(input logic [5:0] pg,
                                       input logic [5:0] top);
        above_top = pg > top;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: straps and panel come from outside
    // straps may move while the clock runs, so every pin gets two stages

    logic        panel_s1, panel_s2;
    logic [2:0]  blk_s1, blk_s2;
    logic [7:0]  en_s1, en_s2;
    logic [3:0]  opt_s1, opt_s2;
    logic        next_panel_s1, next_panel_s2;
    logic [2:0]  next_blk_s1, next_blk_s2;
    logic [7:0]  next_en_s1, next_en_s2;
    logic [3:0]  next_opt_s1, next_opt_s2;

    always_comb begin
        next_panel_s1 = panel_s1;
        next_panel_s2 = panel_s2;
        next_blk_s1  = blk_s1;
        next_blk_s2  = blk_s2;
        next_en_s1   = en_s1;
        next_en_s2   = en_s2;
        next_opt_s1  = opt_s1;
        next_opt_s2  = opt_s2;
        if (clk_en) begin
            next_panel_s1 = panel_fitted;
            next_panel_s2 = panel_s1;
            next_blk_s1  = mem_blocks;
            next_blk_s2  = blk_s1;
            next_en_s1   = irq_enable;
            next_en_s2   = en_s1;
            next_opt_s1  = irq_opt_fit;
            next_opt_s2  = opt_s1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            panel_s1 <= 1'b0;
            panel_s2 <= 1'b0;
            blk_s1  <= 3'h0;
            blk_s2  <= 3'h0;
            en_s1   <= 8'h00;
            en_s2   <= 8'h00;
            opt_s1  <= 4'h0;
            opt_s2  <= 4'h0;
        end else begin
            panel_s1 <= next_panel_s1;
            panel_s2 <= next_panel_s2;
            blk_s1  <= next_blk_s1;
            blk_s2  <= next_blk_s2;
            en_s1   <= next_en_s1;
            en_s2   <= next_en_s2;
            opt_s1  <= next_opt_s1;
            opt_s2  <= next_opt_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt line decoding

    // a line answers only when it exists and software enabled it
    function automatic logic line_live(input logic [7:0] present,
                                       input logic [7:0] en,
                                       input logic [2:0] n);
        line_live = present[n] & en[n];
    endfunction

    logic [7:0] line_present;

    // lines 0-3 always exist, upper four only when fitted
    assign line_present = {opt_s2, 4'hf};

    ////////////////////////////////////////////////////////////////////////
    // installed memory and restart point

    logic [5:0]  next_top_page;
    logic [13:0] next_restart;

    // top page tracks the straps, so a strap change takes effect live
    always_comb begin
        // each 2K adds eight pages; 8 blocks give page 3f
        next_top_page = 6'({blk_s2, 3'h7});
        next_restart  = RESTART_ADDR;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            top_page     <= 6'h07;
            restart_addr <= RESTART_ADDR;
        end else if (clk_en) begin
            top_page     <= next_top_page;
            restart_addr <= next_restart;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt vector and live service block hits

    logic [13:0] next_vector;
    logic        next_line_ok;
    logic [7:0]  next_blk_hit;

    // the vector is registered from irq_line each enabled cycle, one cycle behind
    always_comb begin
        next_vector  = IRQ_BASE + 14'({irq_line, 3'h0});
        next_line_ok = line_live(line_present, en_s2, irq_line);
        next_blk_hit = 8'h00;
        for (int n = 0; n < IRQ_LINES; n++) begin
            // only live blocks flag; idle ones stay plain memory
            if (wr_req_in && line_live(line_present, en_s2, 3'(n)) &&
                wr_addr_in[13:3] == 11'((IRQ_BASE >> IRQ_BLK_SH) + n))
                next_blk_hit[n] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_vector  <= IRQ_BASE;
            irq_line_ok <= 1'b0;
            irq_blk_hit <= 8'h00;
        end else if (clk_en) begin
            irq_vector  <= next_vector;
            irq_line_ok <= next_line_ok;
            irq_blk_hit <= next_blk_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write gate

    logic next_wr_allow;
    logic in_boot_area;

    assign in_boot_area = wr_addr_in < 14'(ROM_BYTES);

    // pages past installed memory are absent core: refuse, never alias
    always_comb begin
        // the panel freezes the boot area; writes above the top page are also blocked
        next_wr_allow = wr_req_in &&
                        !(panel_s2 && in_boot_area) &&
                        page_of(wr_addr_in) <= next_top_page;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_allow <= 1'b0;
        end else if (clk_en) begin
            wr_allow <= next_wr_allow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective address sequencer

    ea_state_t  state, next_state;
    logic [13:0] ptr, next_ptr;
    logic [7:0]  hi_byte, next_hi_byte;
    ea_result_t  next_res;
    logic        next_res_valid;
    logic [5:0]  cur_page;
    logic [13:0] direct_ea;

    // a straddling instruction is judged by its last byte's page
    assign cur_page  = page_of(req.instr_last);
    assign direct_ea = make_addr(req.page_zero ? PAGE_ZERO : cur_page,
                                 req.offset);
    // a new request waits until the word fetch has fully finished
    assign req_ready = (state == ST_IDLE);
    assign rd_req    = (state == ST_HI) || (state == ST_LO);
    assign rd_addr   = ptr;

    always_comb begin
        next_state     = state;
        next_ptr       = ptr;
        next_hi_byte   = hi_byte;
        next_res       = res;
        next_res_valid = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    if (req.indirect) begin
                        next_ptr   = direct_ea;
                        next_state = ST_HI;
                    end else begin
                        next_res.addr                = direct_ea;
                        next_res.auto_increment_flag = 1'b0;
                        next_res.auto_skip_flag      = 1'b0;
                        next_res.fault =
                            above_top(page_of(direct_ea), top_page);
                        next_res_valid = 1'b1;
                    end
                end
            end
            ST_HI: begin
                // strobe holds until core answers; there is no timeout
                if (rd_ack) begin
                    next_hi_byte = rd_data;
                    next_ptr     = ptr + 14'h0001;
                    next_state   = ST_LO;
                end
            end
            ST_LO: begin
                if (rd_ack) begin
                    // keep low 14 bits; flags sit in the word's bits 0,1
                    next_res.addr = {hi_byte[5:0], rd_data};
                    next_res.auto_increment_flag =
                        hi_byte[BYTE_W-1-AUTO_INC_BIT];
                    next_res.auto_skip_flag =
                        hi_byte[BYTE_W-1-AUTO_SKIP_BIT];
                    next_res.fault = above_top(hi_byte[5:0], top_page);
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // result pulses two cycles after the low byte lands
                next_res_valid = 1'b1;
                next_state     = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            ptr       <= 14'h0000;
            hi_byte   <= 8'h00;
            res       <= '0;
            res_valid <= 1'b0;
        end else if (clk_en) begin
            state     <= next_state;
            ptr       <= next_ptr;
            hi_byte   <= next_hi_byte;
            res       <= next_res;
            res_valid <= next_res_valid;
        end
    end

endmodule

// ---- test/paged_effective_address_unit_props.sv ----
// concurrent checks on the paged effective address unit ports
`timescale 1ns/1ps
module ea_props
    import paged_addr_pkg::*;
(
    input wire logic        ref_clk,      // clock
    input wire logic        rst,          // reset
    input wire logic        clk_en,       // run enable
    input wire logic        req_valid,    // request
    input wire mem_ref_t    req,          // request fields
    input wire logic        req_ready,    // idle
    input wire logic        res_valid,    // result pulse
    input wire ea_result_t  res,          // result
    input wire logic        rd_req,       // read strobe
    input wire logic [13:0] rd_addr,      // read address
    input wire logic        rd_ack,       // read ack
    input wire logic [13:0] wr_addr_in,   // write address
    input wire logic        wr_allow,     // write gate
    input wire logic        panel_fitted, // panel pin
    input wire logic [3:0]  irq_opt_fit,  // optional lines
    input wire logic [2:0]  irq_line,     // line asked
    input wire logic [13:0] irq_vector,   // block start
    input wire logic        irq_line_ok,  // line live
    input wire logic [13:0] restart_addr, // restart point
    input wire logic [7:0]  irq_blk_hit,  // block hit
    input wire logic [5:0]  top_page      // top page
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_take;
        clk_en && req_valid && req_ready;
    endsequence
    // high byte taken, strobe stays up, then low byte within the wait bound
    sequence s_pair;
        rd_req && rd_ack ##1 rd_req ##[0:8] rd_ack;
    endsequence
    property p_direct;
        s_take and !req.indirect |=> res_valid && res.addr ==
            {($past(req.page_zero) ? 6'h00 : $past(req.instr_last[13:8])),
             $past(req.offset)};
    endproperty
    property p_ptr;
        s_take and req.indirect |=> rd_req && rd_addr ==
            {($past(req.page_zero) ? 6'h00 : $past(req.instr_last[13:8])),
             $past(req.offset)};
    endproperty
    property p_lo;
        rd_req && rd_ack ##1 rd_req |-> rd_addr == $past(rd_addr) + 14'h1;
    endproperty
    property p_done;
        s_pair |-> ##[1:3] res_valid;
    endproperty
    property p_restart;
        restart_addr == 14'h0000;
    endproperty
    property p_vector;
        clk_en |=> irq_vector == {6'h01, 2'h0, $past(irq_line), 3'h0};
    endproperty
    property p_line;
        irq_line_ok |-> !$past(irq_line[2]) ||
            |($past(irq_opt_fit, 3) & (4'h1 << $past(irq_line[1:0])));
    endproperty
    property p_rom;
        wr_allow && $past(panel_fitted, 3) |->
            $past(wr_addr_in) >= 14'h0040;
    endproperty
    property p_top;
        wr_allow |-> $past(wr_addr_in[13:8]) <= top_page &&
            top_page[2:0] == 3'h7;
    endproperty
    property p_blk;
        irq_blk_hit != 8'h00 |-> $past(wr_addr_in[13:6]) == 8'h04 &&
            irq_blk_hit == 8'h01 << $past(wr_addr_in[5:3]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct address wrong");
    a_ptr: assert property (p_ptr)
        else $error("address word pointer wrong");
    a_lo: assert property (p_lo)
        else $error("low byte not at next address");
    a_done: assert property (p_done)
        else $error("indirect result late");
    a_restart: assert property (p_restart)
        else $error("restart point moved");
    a_vector: assert property (p_vector)
        else $error("service block start wrong");
    a_line: assert property (p_line)
        else $error("absent line reported live");
    a_rom: assert property (p_rom)
        else $error("boot area written");
    a_top: assert property (p_top)
        else $error("write above top page");
    a_blk: assert property (p_blk)
        else $error("service block hit wrong");
endmodule

bind paged_effective_address_unit ea_props u_ea_props (
    .ref_clk, .rst, .clk_en, .req_valid, .req, .req_ready, .res_valid,
    .res, .rd_req, .rd_addr, .rd_ack, .wr_addr_in, .wr_allow,
    .panel_fitted, .irq_opt_fit, .irq_line, .irq_vector, .irq_line_ok,
    .restart_addr, .irq_blk_hit, .top_page);

// ---- test/core_mem_model.sv ----
// core memory stand-in answering byte reads after a set wait
`timescale 1ns/1ps
module core_mem_model (
    input  wire logic        ref_clk,  // clock
    input  wire logic        rd_req,   // read strobe
    input  wire logic [13:0] rd_addr,  // address
    input  wire logic [1:0]  wait_n,   // extra wait cycles
    output logic             rd_ack,   // byte valid
    output logic [7:0]       rd_data   // byte
);
    logic [1:0] cnt = 2'h0;
    logic [7:0] last = 8'h00;
    assign rd_ack = rd_req && (cnt == wait_n);
    // outside an answer show the inverse so stale data never looks valid
    assign rd_data = rd_ack ? (rd_addr[7:0] ^ {rd_addr[13:8], 2'h1}) : ~last;
    always @(posedge ref_clk) begin
        cnt <= (rd_req && !rd_ack) ? cnt + 2'h1 : 2'h0;
        if (rd_ack) begin
            last <= rd_data;
        end
    end
endmodule

// ---- test/paged_effective_address_unit_test.sv ----
// self-checking bench for the paged effective address unit
`timescale 1ns/1ps
module paged_effective_address_unit_test;
    import paged_addr_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        req_valid = 1'b0;
    logic        wr_req_in = 1'b0;
    logic        panel_fitted = 1'b0;
    mem_ref_t    req = '0;
    logic [13:0] wr_addr_in = 14'h0000;
    logic [2:0]  mem_blocks = 3'h3;
    logic [7:0]  irq_enable = 8'hff;
    logic [3:0]  irq_opt_fit = 4'h0;
    logic [2:0]  irq_line = 3'h0;
    logic [1:0]  wait_n = 2'h0;
    logic        req_ready, res_valid, rd_req, rd_ack, wr_allow, irq_line_ok;
    ea_result_t  res;
    logic [13:0] rd_addr, irq_vector, restart_addr;
    logic [7:0]  rd_data, irq_blk_hit;
    logic [5:0]  top_page;
    logic [31:0] seed = 32'h1f;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    paged_effective_address_unit u_paged_effective_address_unit (
        .ref_clk, .rst, .clk_en, .req_valid, .req, .req_ready,
        .res_valid, .res, .rd_req, .rd_addr, .rd_ack, .rd_data, .wr_req_in,
        .wr_addr_in, .wr_allow, .panel_fitted, .mem_blocks, .irq_enable,
        .irq_opt_fit, .irq_line, .irq_vector, .irq_line_ok, .restart_addr,
        .irq_blk_hit, .top_page);
    core_mem_model u_core_mem_model (
        .ref_clk, .rd_req, .rd_addr, .wait_n, .rd_ack, .rd_data);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] byte_at(input logic [13:0] a);
        return a[7:0] ^ {a[13:8], 2'h1};
    endfunction
    function automatic logic live(input logic [2:0] n);
        return irq_enable[n] && (!n[2] || irq_opt_fit[n[1:0]]);
    endfunction
    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic mem_ref(input logic ind, input logic pz,
                           input logic [7:0] off, input logic [13:0] last);
        logic [13:0] ptr;
        logic [7:0]  hi;
        int          i;
        ptr = {pz ? 6'h00 : last[13:8], off};
        hi = byte_at(ptr);
        chk(req_ready, 1'b1);
        req = '{ind, pz, off, last};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        if (ind)
            chk(req_ready, 1'b0);
        for (i = 0; i < 40 && res_valid !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        if (i == 40) begin
            n_mismatch++;
            wrap_up();
        end
        if (ind) begin
            chk(res.addr, {hi[5:0], byte_at(ptr + 14'h1)});
            chk({res.auto_increment_flag, res.auto_skip_flag},
                hi[7:6]);
        end else begin
            chk(res.addr, ptr);
            chk(res.fault, ptr[13:8] > {mem_blocks, 3'h7});
        end
        @(negedge ref_clk);
    endtask
    task automatic wr_pass(input logic pf);
        logic [13:0] a;
        logic [31:0] r;
        panel_fitted = pf;
        repeat (4) @(negedge ref_clk);
        wr_req_in = 1'b1;
        for (int k = 0; k < 60; k++) begin
            r = rnd();
            a = k < 3 ? 14'h003f + 14'(k) :
                k < 11 ? {8'h04, 3'(k - 3), r[2:0]} : r[13:0];
            wr_addr_in = a;
            @(negedge ref_clk);
            chk(wr_allow, !(pf && a < 14'h0040) &&
                a[13:8] <= {mem_blocks, 3'h7});
            chk(irq_blk_hit, (a[13:6] == 8'h04 && live(a[5:3])) ?
                8'h01 << a[5:3] : 8'h00);
        end
        wr_req_in = 1'b0;
        for (int n = 0; n < 8; n++) begin
            irq_line = n[2:0];
            @(negedge ref_clk);
            chk(irq_vector, 14'h0100 + 14'(n * 8));
            chk(irq_line_ok, live(n[2:0]));
        end
    endtask
    initial begin
        logic [31:0] r;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(restart_addr, 14'h0000);
        chk(top_page, {mem_blocks, 3'h7});
        // frozen clock enable must hold the vector of line 0
        clk_en = 1'b0;
        irq_line = 3'h2;
        repeat (3) @(negedge ref_clk);
        chk(irq_vector, 14'h0100);
        clk_en = 1'b1;
        @(negedge ref_clk);
        chk(irq_vector, 14'h0110);
        // second byte already sits in page 5, so page 5 is current
        mem_ref(1'b0, 1'b0, 8'h10, 14'h0500);
        mem_ref(1'b0, 1'b1, 8'hff, 14'h3fff);
        for (int j = 0; j < 40; j++) begin
            r = rnd();
            wait_n = r[1:0];
            mem_ref(r[2], r[3], r[11:4] & {7'h7f, !r[2]}, r[25:12]);
        end
        for (int p = 0; p < 2; p++) begin
            r = rnd();
            irq_enable = r[7:0];
            irq_opt_fit = r[11:8];
            wr_pass(p[0]);
        end
        wrap_up();
    end
endmodule
